// [port_cfg.svh]
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

// command byte field positions
`define CMD3_BIT 0
`define W2_BIT 1
`define CMD2_BIT 3
`define CMD1_BIT 5
`define CMD0_BIT 6
`define W4_HI 3
`define W4_LO 2
`define W8_HI 7
`define W8_LO 4

// command codes
`define CMD_WRITE 4'h0
`define CMD_READ 4'h1

// status line levels
`define ACK_LVL 1'b0
`define NAK_LVL 1'b1

// reset values
`define LINK_RST '0
`define SYS_RST '0

`endif

// [port_pkg.sv]
package port_pkg;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC  = 2'h1,
    MODE_SLAVE = 2'h3
  } mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CMD  = 2'h1,
    ST_TURN = 2'h3,
    ST_DATA = 2'h2
  } slave_e;

  typedef enum logic [1:0] {
    W1 = 2'h0,
    W2 = 2'h1,
    W4 = 2'h2,
    W8 = 2'h3
  } width_e;

  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       oe_n;
    logic       ss_n;
    logic [7:0] bidir_data_lines;
  } port_pins_s;

  typedef struct packed {
    logic [1:0] mode_m;
    mode_e      mode;
    logic       sten_m;
    logic       sten;
    logic       rx_req_m;
    logic       rx_req_s;
    logic       rx_ack;
    logic       tx_ack_m;
    logic       tx_ack_s;
    logic       tx_req;
    logic [7:0] tx_byte;
    logic       rd_m;
    logic       rd_s;
    logic       rd_p;
    logic       wr_m;
    logic       wr_s;
    logic       wr_p;
    logic [7:0] din_m;
    logic [7:0] din_s;
    slave_e     st;
    width_e     wid;
    logic [2:0] beat;
    logic       rd_cmd;
    logic       cmd_ok;
    logic       ok;
    logic [7:0] shreg;
    logic [7:0] dout;
    logic [7:0] doe;
    logic       stat;
    logic       stat_oe;
  } link_s;

  typedef struct packed {
    logic       rx_req;
    logic [7:0] rx_data;
    logic       rx_ack_m;
    logic       rx_ack_s;
    logic       tx_req_m;
    logic       tx_req_s;
    logic       tx_ack;
  } sys_s;

endpackage

// [usb_fifo_host_port_modes.sv]
`timescale 1ns/10ps
`default_nettype none
`include "port_cfg.svh"
module usb_fifo_host_port_modes (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   link_clk,
  input  wire port_pkg::mode_e        mode,
  input  wire logic                   status_en,
  input  wire logic                   rx_in_valid,
  input  wire logic [7:0]             rx_in_data,
  output logic                        rx_in_ready,
  output logic                        tx_out_valid,
  output logic [7:0]                  tx_out_data,
  input  wire logic                   tx_out_ready,
  input  wire port_pkg::port_pins_s   pins,
  output logic                        port_clock_out,
  output logic                        rx_avail_n,
  output logic                        tx_space_n,
  output logic [7:0]                  bidir_data_lines_out,
  output logic [7:0]                  bidir_data_lines_oe,
  output logic                        status_out,
  output logic                        status_oe
);

  port_pkg::link_s l;
  port_pkg::link_s next_l;
  port_pkg::sys_s  s;
  port_pkg::sys_s  next_s;
  logic            rxf;
  logic            txf;
  logic            slave;
  logic            idle_drv;
  logic            take_rx;
  logic            put_tx;
  logic [7:0]      wbyte;
  logic [3:0]      cmd;

  function automatic logic [7:0] lane_mask(input port_pkg::width_e w);
    unique case (w)
      port_pkg::W1: lane_mask = 8'h01;
      port_pkg::W2: lane_mask = 8'h03;
      port_pkg::W4: lane_mask = 8'h0f;
      port_pkg::W8: lane_mask = 8'hff;
    endcase
  endfunction
  function automatic logic [2:0] cmd_last(input port_pkg::width_e w);
    unique case (w)
      port_pkg::W1: cmd_last = 3'h6;
      port_pkg::W2: cmd_last = 3'h3;
      port_pkg::W4: cmd_last = 3'h1;
      port_pkg::W8: cmd_last = 3'h0;
    endcase
  endfunction
  function automatic port_pkg::width_e width_flag_decode(
    input logic [7:0] d);
    if (d[`W8_HI:`W8_LO] != 4'hf)
      width_flag_decode = port_pkg::W8;
    else if (d[`W4_HI:`W4_LO] != 2'h3)
      width_flag_decode = port_pkg::W4;
    else if (!d[`W2_BIT])
      width_flag_decode = port_pkg::W2;
    else
      width_flag_decode = port_pkg::W1;
  endfunction
  function automatic logic [7:0] put_lanes(
    input logic [7:0]       b,
    input logic [7:0]       d,
    input logic [2:0]       bt,
    input port_pkg::width_e w);
    logic [7:0] m;
    logic [2:0] p;
    m = lane_mask(w);
    p = bt << w;
    put_lanes = (b & ~(m << p)) | ((d & m) << p);
  endfunction
  // slot occupancy from toggle handshakes
  assign rxf = l.rx_req_s ^ l.rx_ack;
  assign txf = l.tx_req ^ l.tx_ack_s;
  assign cmd = {l.shreg[`CMD3_BIT], l.shreg[`CMD2_BIT],
                l.shreg[`CMD1_BIT], l.shreg[`CMD0_BIT]};

  // link side; sync and slave pins are on this clock
  always_comb
  begin
    next_l = l;
    take_rx = 1'b0;
    put_tx = 1'b0;
    wbyte = pins.bidir_data_lines;
    next_l.mode_m = mode;
    next_l.mode = port_pkg::mode_e'(l.mode_m);
    next_l.sten_m = status_en;
    next_l.sten = l.sten_m;
    next_l.rx_req_m = s.rx_req;
    next_l.rx_req_s = l.rx_req_m;
    next_l.tx_ack_m = s.tx_ack;
    next_l.tx_ack_s = l.tx_ack_m;
    next_l.rd_m = ~pins.rd_n;
    next_l.rd_s = l.rd_m;
    next_l.rd_p = l.rd_s;
    next_l.wr_m = ~pins.wr_n;
    next_l.wr_s = l.wr_m;
    next_l.wr_p = l.wr_s;
    next_l.din_m = pins.bidir_data_lines;
    next_l.din_s = l.din_m;
    next_l.doe = 8'h00;
    next_l.stat_oe = 1'b0;
    next_l.stat = `NAK_LVL;
    unique case (l.mode)
      port_pkg::MODE_SYNC:
      begin
        next_l.dout = s.rx_data;
        if (!pins.oe_n)
        begin
          next_l.doe = 8'hff;
          take_rx = !pins.rd_n && rxf;
        end
        else
          put_tx = !pins.wr_n && !txf;
      end
      port_pkg::MODE_ASYNC:
      begin
        next_l.doe = {8{l.rd_s}};
        if (!l.rd_s)
          next_l.dout = s.rx_data;
        take_rx = !l.rd_p && l.rd_s && rxf;
        put_tx = !l.wr_p && l.wr_s && !txf;
        wbyte = l.din_s;
      end
      port_pkg::MODE_SLAVE:
      begin
        if (pins.ss_n)
          next_l.st = port_pkg::ST_IDLE;
        else
        begin
          unique case (l.st)
            port_pkg::ST_IDLE:
            begin
              next_l.wid = width_flag_decode(pins.bidir_data_lines);
              next_l.shreg = pins.bidir_data_lines;
              next_l.beat = 3'h1;
              if (cmd_last(next_l.wid) == 3'h0)
                next_l.st = port_pkg::ST_TURN;
              else
                next_l.st = port_pkg::ST_CMD;
            end
            port_pkg::ST_CMD:
            begin
              next_l.shreg = put_lanes(l.shreg, pins.bidir_data_lines,
                                       l.beat, l.wid);
              next_l.beat = l.beat + 3'h1;
              if (l.beat == cmd_last(l.wid))
                next_l.st = port_pkg::ST_TURN;
            end
            port_pkg::ST_TURN:
            begin
              next_l.rd_cmd = (cmd == `CMD_READ);
              next_l.cmd_ok = next_l.rd_cmd || (cmd == `CMD_WRITE);
              next_l.ok = next_l.rd_cmd ? rxf : next_l.cmd_ok && !txf;
              next_l.shreg = s.rx_data;
              next_l.dout = s.rx_data;
              next_l.beat = 3'h0;
              next_l.st = port_pkg::ST_DATA;
            end
            port_pkg::ST_DATA:
            begin
              next_l.beat = l.beat + 3'h1;
              if (l.rd_cmd)
                next_l.dout = l.shreg >> (next_l.beat << l.wid);
              else
                next_l.shreg = put_lanes(l.shreg, pins.bidir_data_lines,
                                         l.beat, l.wid);
              if (l.beat == 3'(3'h7 >> l.wid))
              begin
                next_l.beat = 3'h0;
                wbyte = next_l.shreg;
                take_rx = l.rd_cmd && l.ok;
                put_tx = !l.rd_cmd && l.ok;
                if (l.rd_cmd)
                begin
                  next_l.ok = l.cmd_ok && rxf && !take_rx;
                  next_l.shreg = s.rx_data;
                  next_l.dout = s.rx_data;
                end
                else
                  next_l.ok = l.cmd_ok && !txf && !put_tx;
              end
            end
          endcase
          if (next_l.st == port_pkg::ST_DATA)
          begin
            next_l.doe = next_l.rd_cmd ? lane_mask(l.wid) : 8'h00;
            next_l.stat_oe = 1'b1;
            next_l.stat = next_l.ok ? `ACK_LVL : `NAK_LVL;
          end
        end
      end
      default: next_l.doe = 8'h00;
    endcase
    if (take_rx)
      next_l.rx_ack = ~l.rx_ack;
    if (put_tx)
    begin
      next_l.tx_byte = wbyte;
      next_l.tx_req = ~l.tx_req;
    end
  end

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
      l <= `LINK_RST;
    else
      l <= next_l;
  end

  // system side of the slot handshakes
  assign rx_in_ready = (s.rx_req == s.rx_ack_s);
  assign tx_out_valid = (s.tx_req_s != s.tx_ack);
  assign tx_out_data = l.tx_byte;

  always_comb
  begin
    next_s = s;
    next_s.rx_ack_m = l.rx_ack;
    next_s.rx_ack_s = s.rx_ack_m;
    next_s.tx_req_m = l.tx_req;
    next_s.tx_req_s = s.tx_req_m;
    if (rx_in_valid && rx_in_ready)
    begin
      next_s.rx_data = rx_in_data;
      next_s.rx_req = ~s.rx_req;
    end
    if (tx_out_valid && tx_out_ready)
      next_s.tx_ack = ~s.tx_ack;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s <= `SYS_RST;
    else
      s <= next_s;
  end

  // pin drivers
  assign slave = (l.mode == port_pkg::MODE_SLAVE);
  assign idle_drv = slave && pins.ss_n;
  assign rx_avail_n = ~rxf;
  assign tx_space_n = txf;
  assign port_clock_out = link_clk & (l.mode == port_pkg::MODE_SYNC);
  assign bidir_data_lines_out = idle_drv ? {7'h00, txf} : l.dout;
  assign bidir_data_lines_oe = idle_drv ? {7'h00, l.sten} :
    (slave && l.st == port_pkg::ST_IDLE) ? 8'h00 : l.doe;
  assign status_out = idle_drv ? ~rxf : l.stat;
  assign status_oe = idle_drv ? l.sten : l.stat_oe;

  sequence s_frame_1bit;
    slave && l.st == port_pkg::ST_IDLE && !pins.ss_n &&
      pins.bidir_data_lines[7:1] == 7'h7f;
  endsequence
  sequence s_sync_read;
    l.mode == port_pkg::MODE_SYNC && !pins.oe_n && !pins.rd_n && rxf;
  endsequence
  a_cmd_length:
  assert property (@(posedge link_clk) disable iff (!nrst)
    s_frame_1bit ##1 (!pins.ss_n)[*6] |=> l.st == port_pkg::ST_TURN)
    else $error("1-bit command phase length wrong");
  a_one_dir:
  assert property (@(posedge link_clk) disable iff (!nrst)
    !(take_rx && put_tx))
    else $error("read and write in the same cycle");
  a_sync_read:
  assert property (@(posedge link_clk) disable iff (!nrst)
    s_sync_read |=> (!rxf)[*2])
    else $error("sync read did not consume the byte");
  a_sync_write:
  assert property (@(posedge link_clk) disable iff (!nrst)
    (l.mode == port_pkg::MODE_SYNC && pins.oe_n && !pins.wr_n && !txf)
    |=> txf && l.tx_byte == $past(pins.bidir_data_lines))
    else $error("sync write byte not taken");
  a_write_refused:
  assert property (@(posedge link_clk) disable iff (!nrst)
    (l.mode == port_pkg::MODE_SYNC && (txf || !pins.oe_n))
    |=> $stable(l.tx_req))
    else $error("write taken while refused");
  a_oe_drive:
  assert property (@(posedge link_clk) disable iff (!nrst)
    (l.mode == port_pkg::MODE_SYNC && !pins.oe_n)
    |=> bidir_data_lines_oe == 8'hff &&
        bidir_data_lines_out == $past(s.rx_data))
    else $error("bus not driven with receive byte");
  a_async_read:
  assert property (@(posedge link_clk) disable iff (!nrst)
    (l.mode == port_pkg::MODE_ASYNC && !l.rd_p && l.rd_s && rxf)
    |=> !rxf)
    else $error("async read edge did not consume");
  a_width_decode:
  assert property (@(posedge link_clk) disable iff (!nrst)
    (slave && l.st == port_pkg::ST_IDLE && !pins.ss_n &&
     pins.bidir_data_lines[7:4] != 4'hf) |=> l.wid == port_pkg::W8)
    else $error("8-bit width not decoded");
  a_stop_drive:
  assert property (@(posedge link_clk) disable iff (!nrst)
    (slave && !pins.ss_n && l.st == port_pkg::ST_IDLE)
    |-> bidir_data_lines_oe == 8'h00)
    else $error("line 0 driven after select");

endmodule
`default_nettype wire

// [host_master.sv]
`timescale 1ns/10ps
`default_nettype none
module host_master (
  input  wire logic            link_clk,
  input  wire logic [7:0]      dev_out,
  input  wire logic [7:0]      dev_oe,
  output port_pkg::port_pins_s pins
);
  logic [3:0] ctl = 4'hf;
  logic [7:0] men = 8'h00;
  logic [7:0] mdat = 8'h00;
  always_comb
  begin
    {pins.rd_n, pins.wr_n, pins.oe_n, pins.ss_n} = ctl;
    // released lines float high through pull-ups
    pins.bidir_data_lines = (dev_oe & dev_out) | (~dev_oe & men & mdat)
      | (~dev_oe & ~men);
  end
  // strobes, lane enables and lane data move together after one link edge
  task automatic drive(input logic [3:0] c, input logic [7:0] e,
    input logic [7:0] d);
    @(posedge link_clk);
    ctl <= c;
    men <= e;
    mdat <= d;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                clk = 1'b0;
  logic                link_clk = 1'b0;
  logic                nrst = 1'b0;
  port_pkg::mode_e     mode = port_pkg::MODE_ASYNC;
  logic                status_en = 1'b1;
  logic                rx_in_valid = 1'b0;
  logic [7:0]          rx_in_data = 8'h00;
  logic                tx_out_ready = 1'b0;
  logic                rx_in_ready;
  logic                tx_out_valid;
  logic [7:0]          tx_out_data;
  logic                port_clock_out;
  logic                rx_avail_n;
  logic                tx_space_n;
  logic [7:0]          lout;
  logic [7:0]          loe;
  logic                status_out;
  logic                status_oe;
  port_pkg::port_pins_s pins;
  int                  num_errors = 0;
  int                  n_tests = 0;
  initial forever #50 clk = ~clk;
  initial
  begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  usb_fifo_host_port_modes dut_u (
    .clk(clk), .nrst(nrst), .link_clk(link_clk), .mode(mode),
    .status_en(status_en), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready), .pins(pins),
    .port_clock_out(port_clock_out), .rx_avail_n(rx_avail_n),
    .tx_space_n(tx_space_n), .bidir_data_lines_out(lout),
    .bidir_data_lines_oe(loe), .status_out(status_out),
    .status_oe(status_oe));
  host_master m_u (
    .link_clk(link_clk), .dev_out(lout), .dev_oe(loe), .pins(pins));
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return rx_avail_n;
      1: return tx_space_n;
      2: return tx_out_valid;
      default: return rx_in_ready;
    endcase
  endfunction
  // bounded wait on a flag, sampled clear of the clock edge
  task automatic wt(input int k, input logic v);
    repeat (80)
    begin
      @(posedge clk);
      #1;
      if (sel(k) === v)
        return;
    end
    num_errors++;
    $display("CHECK FAILED t=%0t flag %0d stuck", $time, k);
    finish_test();
  endtask
  task automatic push(input logic [7:0] b);
    wt(3, 1'b1);
    @(posedge clk);
    rx_in_valid <= 1'b1;
    rx_in_data <= b;
    @(posedge clk);
    rx_in_valid <= 1'b0;
  endtask
  task automatic pop(input logic [7:0] b);
    wt(2, 1'b1);
    chk(tx_out_data, b);
    @(posedge clk);
    tx_out_ready <= 1'b1;
    @(posedge clk);
    tx_out_ready <= 1'b0;
  endtask
  task automatic set_mode(input port_pkg::mode_e m);
    @(posedge clk);
    mode <= m;
    repeat (4) @(posedge link_clk);
    #1;
  endtask
  task automatic t_reset;
    chk({2'b00, rx_avail_n, tx_space_n, status_oe, rx_in_ready,
      tx_out_valid, port_clock_out}, 8'h24);
    chk(loe, 8'h00);
    $display("done reset");
  endtask
  task automatic t_sync;
    set_mode(port_pkg::MODE_SYNC);
    @(posedge link_clk);
    #1;
    chk({7'h00, port_clock_out}, 8'h01);
    @(negedge link_clk);
    #1;
    chk({7'h00, port_clock_out}, 8'h00);
    push(8'ha5);
    wt(0, 1'b0);
    m_u.drive(4'hd, 8'h00, 8'h00);
    m_u.drive(4'h5, 8'h00, 8'h00);
    #1;
    chk(loe, 8'hff);
    chk(lout, 8'ha5);
    m_u.drive(4'hf, 8'h00, 8'h00);
    #1;
    chk({7'h00, rx_avail_n}, 8'h01);
    wt(1, 1'b0);
    m_u.drive(4'hb, 8'hff, 8'h3c);
    m_u.drive(4'hb, 8'hff, 8'h99);
    #1;
    chk({7'h00, tx_space_n}, 8'h01);
    m_u.drive(4'hf, 8'h00, 8'h00);
    pop(8'h3c);
    wt(1, 1'b0);
    repeat (6) @(posedge clk);
    chk({7'h00, tx_out_valid}, 8'h00);
    $display("done sync");
  endtask
  task automatic t_idle;
    set_mode(port_pkg::MODE_SLAVE);
    chk({loe[0], lout[0], status_oe, status_out, 4'h0}, 8'hb0);
    @(posedge clk);
    status_en <= 1'b0;
    repeat (4) @(posedge link_clk);
    #1;
    chk({loe[0], status_oe, 6'h00}, 8'h00);
    @(posedge clk);
    status_en <= 1'b1;
    repeat (4) @(posedge link_clk);
    $display("done idle");
  endtask
  task automatic t_wr1;
    logic [7:0] c;
    logic [7:0] w;
    c = 8'h96;
    w = 8'h3c;
    for (int i = 0; i < 7; i++)
    begin
      m_u.drive(4'he, 8'h01, {7'h00, c[i]});
      #1;
      if (i == 0)
        chk({7'h00, loe[0]}, 8'h00);
    end
    m_u.drive(4'he, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      m_u.drive(4'he, 8'h01, {7'h00, w[i]});
      #1;
      if (i == 0)
        chk({6'h00, status_oe, status_out}, 8'h02);
    end
    m_u.drive(4'he, 8'h00, 8'h00);
    m_u.drive(4'hf, 8'h00, 8'h00);
    repeat (3) @(posedge link_clk);
    #1;
    chk({6'h00, loe[0], lout[0]}, 8'h03);
    pop(w);
    $display("done wr1");
  endtask
  task automatic t_rd8;
    push(8'h5a);
    wt(0, 1'b0);
    repeat (4) @(posedge link_clk);
    #1;
    chk({7'h00, status_out}, 8'h00);
    m_u.drive(4'he, 8'hff, 8'hc6);
    m_u.drive(4'he, 8'h00, 8'h00);
    m_u.drive(4'he, 8'h00, 8'h00);
    #1;
    chk(loe, 8'hff);
    chk(lout, 8'h5a);
    chk({6'h00, status_oe, status_out}, 8'h02);
    m_u.drive(4'he, 8'h00, 8'h00);
    #1;
    chk({7'h00, status_out}, 8'h01);
    m_u.drive(4'hf, 8'h00, 8'h00);
    wt(3, 1'b1);
    $display("done rd8");
  endtask
  task automatic t_async;
    set_mode(port_pkg::MODE_ASYNC);
    chk({6'h00, port_clock_out, loe[0]}, 8'h00);
    push(8'h69);
    wt(0, 1'b0);
    m_u.drive(4'h7, 8'h00, 8'h00);
    repeat (3) @(posedge link_clk);
    #1;
    chk(loe, 8'hff);
    chk(lout, 8'h69);
    chk({7'h00, rx_avail_n}, 8'h01);
    m_u.drive(4'hf, 8'h00, 8'h00);
    repeat (3) @(posedge link_clk);
    #1;
    chk(loe, 8'h00);
    wt(1, 1'b0);
    m_u.drive(4'hb, 8'hff, 8'hc3);
    repeat (3) @(posedge link_clk);
    #1;
    chk({7'h00, tx_space_n}, 8'h01);
    m_u.drive(4'hf, 8'h00, 8'h00);
    pop(8'hc3);
    $display("done async");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_sync();
    t_idle();
    t_wr1();
    t_rd8();
    t_async();
    finish_test();
  end
endmodule
`default_nettype wire
